// ### include/ssb_regs.vh
// register offsets, field positions and reset values of the serial status and rate block
`ifndef SSB_REGS_VH
`define SSB_REGS_VH

// byte offsets on the register bus
`define SSB_OFS_STATUS 8'h00
`define SSB_OFS_DIVIDER 8'h04
`define SSB_OFS_CONTROL 8'h08
`define SSB_OFS_TXHOLD 8'h0C
`define SSB_OFS_RXHOLD 8'h10

// serial_status field positions
`define SSB_ST_TXEMPTY 7
`define SSB_ST_RXFULL 6
`define SSB_ST_OER 5
`define SSB_ST_FRAMING 4
`define SSB_ST_PARITY 3
`define SSB_ST_TXEND 2
`define SSB_ST_RXMP 1
`define SSB_ST_TXMP 0

// serial_control field positions
`define SSB_CT_TXEN 0
`define SSB_CT_RXEN 1
`define SSB_CT_SYNC 2
`define SSB_CT_PAREN 3
`define SSB_CT_PSENSE 4
`define SSB_CT_MPEN 5
`define SSB_CT_CKS_LO 6
`define SSB_CT_CKS_HI 7

// reset values
`define SSB_RST_STATUS 8'h84
`define SSB_RST_DIVIDER 8'hFF
`define SSB_RST_CONTROL 8'h00

// clock-select codes
`define SSB_CKS_SYS 2'b00
`define SSB_CKS_SUB 2'b01
`define SSB_CKS_DIV16 2'b10
`define SSB_CKS_DIV64 2'b11

// prescaler terminal counts and fixed oversampling of one bit period
`define SSB_PRE16_LAST 6'h0F
`define SSB_PRE64_LAST 6'h3F
`define SSB_OVER_LAST 6'h3F

// bus responses
`define SSB_RESP_OKAY 2'b00
`define SSB_RESP_SLVERR 2'b10

`endif

// ### verilog/ssb_top.v
// serial status flags, rate divider and async bit-rate generator behind an axi4-lite slave
`timescale 1ns/1ps
`include "ssb_regs.vh"

module ssb_top (
  input wire CLK_IN,
  input wire RST_IN,
  // low-power state inputs and the watch clock; only standby reinitialises the block
  input wire STANDBY_IN,
  input wire SUBACTIVE_IN,
  input wire WATCH_CLK_IN,
  // axi4-lite slave
  input wire [7:0] AWADDR_IN,
  input wire AWVALID_IN,
  output reg AWREADY_OUT,
  input wire [31:0] WDATA_IN,
  input wire [3:0] WSTRB_IN,
  input wire WVALID_IN,
  output reg WREADY_OUT,
  output reg [1:0] BRESP_OUT,
  output reg BVALID_OUT,
  input wire BREADY_IN,
  input wire [7:0] ARADDR_IN,
  input wire ARVALID_IN,
  output reg ARREADY_OUT,
  output reg [31:0] RDATA_OUT,
  output reg [1:0] RRESP_OUT,
  output reg RVALID_OUT,
  input wire RREADY_IN,
  // received characters from the frame logic
  input wire [7:0] RX_DATA_IN,
  input wire RX_PARITY_IN,
  input wire RX_MPB_IN,
  input wire RX_STOP_IN,
  input wire RX_VALID_IN,
  output reg RX_READY_OUT,
  // characters handed to the transmit shifter
  output reg [7:0] TX_DATA_OUT,
  output reg TX_MPB_OUT,
  output reg TX_VALID_OUT,
  input wire TX_READY_IN,
  input wire TX_LAST_BIT_IN,
  // one pulse per asynchronous bit period
  output reg BAUD_TICK_OUT
);

  // true when the byte offset names a mapped register
  function is_mapped;
    input [7:0] ofs;
    begin
      is_mapped = (ofs == `SSB_OFS_STATUS) || (ofs == `SSB_OFS_DIVIDER) ||
        (ofs == `SSB_OFS_CONTROL) || (ofs == `SSB_OFS_TXHOLD) ||
        (ofs == `SSB_OFS_RXHOLD);
    end
  endfunction

  // register state
  reg [7:0] bit_rate_divider; // software divider value N
  reg [7:0] serial_control; // mode and enable bits
  reg [7:0] tx_holding_register; // last byte written for transmit
  reg [7:0] rx_holding_register; // last byte moved from the buffer
  reg tx_holding_empty_flag;
  reg rx_holding_full_flag;
  reg overrun_flag;
  reg framing_error_flag;
  reg parity_error_flag;
  reg transmit_end_flag;
  reg rx_multiproc_bit;
  reg tx_multiproc_bit;
  reg [7:0] seen_one; // flags read as one since their last clear

  // bus-side holding state
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;

  // receive buffer: two entries of {stop, mpb, parity, data}
  reg [10:0] rx_mem [0:1];
  reg rx_wr_idx;
  reg rx_rd_idx;
  reg [1:0] rx_count;

  // rate generator state
  reg watch_prev;
  reg watch_half;
  reg [5:0] pre_cnt;
  reg [7:0] div_cnt;
  reg [5:0] over_cnt;

  wire [7:0] status_value = {tx_holding_empty_flag, rx_holding_full_flag, overrun_flag,
    framing_error_flag, parity_error_flag, transmit_end_flag, rx_multiproc_bit,
    tx_multiproc_bit};
  wire tx_on = serial_control[`SSB_CT_TXEN];
  wire rx_on = serial_control[`SSB_CT_RXEN];
  wire sync_mode = serial_control[`SSB_CT_SYNC];
  wire async_mp = !sync_mode && serial_control[`SSB_CT_MPEN];
  wire [1:0] cks = {serial_control[`SSB_CT_CKS_HI], serial_control[`SSB_CT_CKS_LO]};

  // bus events of this cycle
  wire do_write = aw_got && w_got && !BVALID_OUT;
  wire do_read = ARVALID_IN && ARREADY_OUT;
  wire wr_status = do_write && w_lane0 && (aw_addr == `SSB_OFS_STATUS);
  wire wr_txhold = do_write && w_lane0 && (aw_addr == `SSB_OFS_TXHOLD);
  wire rd_status = do_read && (ARADDR_IN == `SSB_OFS_STATUS);
  wire rd_rxhold = do_read && (ARADDR_IN == `SSB_OFS_RXHOLD);
  // a zero written to a flag only clears after that flag was read as one
  wire [7:0] clr_ok = wr_status ? (~w_byte & seen_one) : 8'h00;

  // reception halts on any pending error; in sync mode transmission halts on a framing or overrun error
  wire rx_blocked = parity_error_flag || framing_error_flag || overrun_flag;
  wire tx_blocked = sync_mode && (framing_error_flag || overrun_flag);

  // buffer handshakes on both sides
  wire rx_push = RX_VALID_IN && RX_READY_OUT;
  wire rx_pop = (rx_count != 2'b00) && !rx_blocked;
  wire [10:0] rx_head = rx_mem[rx_rd_idx];
  wire [1:0] next_rx_count = rx_count + {1'b0, rx_push} - {1'b0, rx_pop};

  // checks on the character leaving the buffer
  wire par_bad = !sync_mode && serial_control[`SSB_CT_PAREN] &&
    ((^rx_head[8:0]) != serial_control[`SSB_CT_PSENSE]);
  wire frm_bad = !sync_mode && !rx_head[10];
  wire rx_take = rx_pop && rx_on; // receive disabled: flags and data stay put

  // transmit handover and character end
  wire tx_move = TX_VALID_OUT && TX_READY_IN;
  wire tx_end_evt = TX_LAST_BIT_IN && tx_holding_empty_flag;

  // write channel: address and data taken in either order, response after both
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      AWREADY_OUT <= 1'b1;
      WREADY_OUT <= 1'b1;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= `SSB_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_got <= 1'b1;
        aw_addr <= AWADDR_IN;
        AWREADY_OUT <= 1'b0;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_got <= 1'b1;
        w_byte <= WDATA_IN[7:0];
        w_lane0 <= WSTRB_IN[0]; // only the low lane carries register bits
        WREADY_OUT <= 1'b0;
      end
      if (do_write) begin
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= is_mapped(aw_addr) ? `SSB_RESP_OKAY : `SSB_RESP_SLVERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      // channels reopen only once the response is gone, one write at a time
      if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
        AWREADY_OUT <= 1'b1;
        WREADY_OUT <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      ARREADY_OUT <= 1'b1;
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0000_0000;
      RRESP_OUT <= `SSB_RESP_OKAY;
    end else begin
      if (do_read) begin
        ARREADY_OUT <= 1'b0;
        RVALID_OUT <= 1'b1;
        RRESP_OUT <= is_mapped(ARADDR_IN) ? `SSB_RESP_OKAY : `SSB_RESP_SLVERR;
        case (ARADDR_IN)
          `SSB_OFS_STATUS: RDATA_OUT <= {24'h00_0000, status_value};
          `SSB_OFS_DIVIDER: RDATA_OUT <= {24'h00_0000, bit_rate_divider};
          `SSB_OFS_CONTROL: RDATA_OUT <= {24'h00_0000, serial_control};
          `SSB_OFS_TXHOLD: RDATA_OUT <= {24'h00_0000, tx_holding_register};
          `SSB_OFS_RXHOLD: RDATA_OUT <= {24'h00_0000, rx_holding_register};
          default: RDATA_OUT <= 32'h0000_0000;
        endcase
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
        ARREADY_OUT <= 1'b1;
      end
    end
  end

  // plain read/write registers; standby reloads them like a reset
  always @(posedge CLK_IN) begin
    if (RST_IN || STANDBY_IN) begin
      bit_rate_divider <= `SSB_RST_DIVIDER;
      serial_control <= `SSB_RST_CONTROL;
      tx_holding_register <= 8'h00;
    end else if (do_write && w_lane0) begin
      case (aw_addr)
        `SSB_OFS_DIVIDER: bit_rate_divider <= w_byte;
        `SSB_OFS_CONTROL: serial_control <= w_byte;
        `SSB_OFS_TXHOLD: tx_holding_register <= w_byte;
        default: serial_control <= serial_control;
      endcase
    end
  end

  // status flags; within each flag the hardware set is written last so it wins
  always @(posedge CLK_IN) begin
    if (RST_IN || STANDBY_IN) begin
      {tx_holding_empty_flag, rx_holding_full_flag, overrun_flag, framing_error_flag,
        parity_error_flag, transmit_end_flag, rx_multiproc_bit,
        tx_multiproc_bit} <= `SSB_RST_STATUS;
      seen_one <= 8'h00;
      rx_holding_register <= 8'h00;
      TX_DATA_OUT <= 8'h00;
      TX_MPB_OUT <= 1'b0;
      TX_VALID_OUT <= 1'b0;
    end else begin
      // remember which flags software has seen as one
      if (rd_status) begin
        seen_one <= (seen_one | status_value) & ~clr_ok;
      end else begin
        seen_one <= seen_one & ~clr_ok;
      end
      // software clears: only zeros count, ones are ignored
      if (clr_ok[`SSB_ST_TXEMPTY]) begin
        tx_holding_empty_flag <= 1'b0;
        transmit_end_flag <= 1'b0;
      end
      if (clr_ok[`SSB_ST_RXFULL] || rd_rxhold) begin
        rx_holding_full_flag <= 1'b0;
      end
      if (clr_ok[`SSB_ST_OER]) begin
        overrun_flag <= 1'b0;
      end
      if (clr_ok[`SSB_ST_FRAMING]) begin
        framing_error_flag <= 1'b0;
      end
      if (clr_ok[`SSB_ST_PARITY]) begin
        parity_error_flag <= 1'b0;
      end
      // the multiproc transmit bit is plain read/write
      if (wr_status) begin
        tx_multiproc_bit <= w_byte[`SSB_ST_TXMP];
      end
      // a data write empties nothing but marks the holding register full
      if (wr_txhold) begin
        tx_holding_empty_flag <= 1'b0;
        transmit_end_flag <= 1'b0;
      end
      // transmit side: offer the held byte once it is loaded and allowed
      if (!tx_on) begin
        TX_VALID_OUT <= 1'b0;
        tx_holding_empty_flag <= 1'b1;
        transmit_end_flag <= 1'b1;
      end else if (tx_move) begin
        TX_VALID_OUT <= 1'b0;
        tx_holding_empty_flag <= 1'b1;
      end else if (!TX_VALID_OUT && !tx_holding_empty_flag && !wr_txhold && !tx_blocked) begin
        TX_VALID_OUT <= 1'b1;
        TX_DATA_OUT <= tx_holding_register;
        TX_MPB_OUT <= async_mp && tx_multiproc_bit;
      end
      if (tx_on && tx_end_evt) begin
        transmit_end_flag <= 1'b1;
      end
      // receive side: parity and framing errors still store data but leave the full flag clear
      if (rx_take) begin
        if (rx_holding_full_flag && !clr_ok[`SSB_ST_RXFULL] && !rd_rxhold) begin
          overrun_flag <= 1'b1; // character lost, old data kept
        end else begin
          rx_holding_register <= rx_head[7:0];
          if (par_bad) begin
            parity_error_flag <= 1'b1;
          end
          if (frm_bad) begin
            framing_error_flag <= 1'b1;
          end
          if (!par_bad && !frm_bad) begin
            rx_holding_full_flag <= 1'b1;
          end
        end
        if (async_mp) begin
          rx_multiproc_bit <= rx_head[9];
        end
      end
    end
  end

  // two-entry receive buffer; its ready reaches the frame logic
  always @(posedge CLK_IN) begin
    if (RST_IN || STANDBY_IN) begin
      rx_wr_idx <= 1'b0;
      rx_rd_idx <= 1'b0;
      rx_count <= 2'b00;
      RX_READY_OUT <= 1'b1;
      rx_mem[0] <= 11'h000;
      rx_mem[1] <= 11'h000;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wr_idx] <= {RX_STOP_IN, RX_MPB_IN, RX_PARITY_IN, RX_DATA_IN};
        rx_wr_idx <= ~rx_wr_idx;
      end
      if (rx_pop) begin
        rx_rd_idx <= ~rx_rd_idx;
      end
      rx_count <= next_rx_count;
      // registered ready: stalls one cycle early rather than overfilling
      RX_READY_OUT <= (next_rx_count == 2'b00) ||
        ((next_rx_count == 2'b01) && !rx_push);
    end
  end

  // generator input: system clock, sub-clock, /16 or /64
  wire watch_rise = WATCH_CLK_IN && !watch_prev;
  // sub-clock: half watch clock when active, full watch clock when subactive
  wire sub_tick = watch_rise && (SUBACTIVE_IN || watch_half);
  reg gen_tick;
  always @* begin
    case (cks)
      `SSB_CKS_SYS: gen_tick = 1'b1;
      `SSB_CKS_SUB: gen_tick = sub_tick;
      `SSB_CKS_DIV16: gen_tick = ({2'b00, pre_cnt[3:0]} == `SSB_PRE16_LAST);
      `SSB_CKS_DIV64: gen_tick = (pre_cnt == `SSB_PRE64_LAST);
      default: gen_tick = 1'b0;
    endcase
  end

  // divide generator input by N+1, then by 64, for one bit period
  always @(posedge CLK_IN) begin
    if (RST_IN || STANDBY_IN) begin
      watch_prev <= 1'b0;
      watch_half <= 1'b0;
      pre_cnt <= 6'h00;
      div_cnt <= 8'h00;
      over_cnt <= 6'h00;
      BAUD_TICK_OUT <= 1'b0;
    end else begin
      watch_prev <= WATCH_CLK_IN;
      if (watch_rise) begin
        watch_half <= ~watch_half;
      end
      pre_cnt <= pre_cnt + 6'h01;
      BAUD_TICK_OUT <= 1'b0;
      // generator idles with both enables off, so the rate starts from phase zero
      if (!tx_on && !rx_on) begin
        div_cnt <= 8'h00;
        over_cnt <= 6'h00;
      end else if (gen_tick) begin
        if (div_cnt >= bit_rate_divider) begin
          div_cnt <= 8'h00;
          over_cnt <= over_cnt + 6'h01;
          if (over_cnt == `SSB_OVER_LAST) begin
            BAUD_TICK_OUT <= !sync_mode;
          end
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

endmodule

// ### test/ssb_chk_assertions.sv
// checker: bus handshakes, transmit hand-off and tick spacing seen at the top ports
`timescale 1ns/1ps
module ssb_chk (
  input wire CLK_IN,
  input wire RST_IN,
  input wire STANDBY_IN,
  input wire AWVALID_IN,
  input wire AWREADY_OUT,
  input wire WVALID_IN,
  input wire WREADY_OUT,
  input wire [1:0] BRESP_OUT,
  input wire BVALID_OUT,
  input wire BREADY_IN,
  input wire ARVALID_IN,
  input wire ARREADY_OUT,
  input wire [31:0] RDATA_OUT,
  input wire RVALID_OUT,
  input wire RREADY_IN,
  input wire [7:0] TX_DATA_OUT,
  input wire TX_MPB_OUT,
  input wire TX_VALID_OUT,
  input wire TX_READY_IN,
  input wire BAUD_TICK_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  wr_answer_a: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |-> ##2 BVALID_OUT)
    else $error("write response missing");
  rd_answer_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read response missing");
  b_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped early");
  r_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data dropped early");
  rd_width_a: assert property (RVALID_OUT |-> RDATA_OUT[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  w_block_a: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
    else $error("write accepted while response pending");
  // a register write or standby may legally withdraw the character, so those cycles are excluded
  tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN && !AWVALID_IN && !$past(AWVALID_IN)
    && !$past(AWVALID_IN, 2) && !STANDBY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT)
    && $stable(TX_MPB_OUT))
    else $error("transmit character changed before taken");
  tick_gap_a: assert property (BAUD_TICK_OUT |=> !BAUD_TICK_OUT [*8])
    else $error("bit ticks too close");
  rst_idle_a: assert property ($fell(RST_IN) |-> AWREADY_OUT && ARREADY_OUT && !BVALID_OUT
    && !RVALID_OUT && !TX_VALID_OUT && !BAUD_TICK_OUT)
    else $error("outputs not idle after reset");
  cover property (BVALID_OUT && BREADY_IN);
  cover property (RVALID_OUT && RREADY_IN);
  cover property (TX_VALID_OUT && TX_READY_IN);
  cover property (BAUD_TICK_OUT);
endmodule
bind ssb_top ssb_chk ssb_chk_inst (.*);

// ### test/ssb_partner.sv
// far-side model: receive front end offering characters, transmit shifter taking them
`timescale 1ns/1ps
module ssb_partner (
  input wire clk_in,
  input wire rx_ready_in,
  output reg [7:0] rx_data_out,
  output reg rx_parity_out,
  output reg rx_mpb_out,
  output reg rx_stop_out,
  output reg rx_valid_out,
  input wire tx_valid_in,
  output reg tx_ready_out,
  output reg tx_last_bit_out
);
  integer stall = 0; // cycles the shifter makes a character wait
  integer waited = 0;
  integer tx_count = 0; // characters fully shifted out
  integer shift_left = 0; // cycles until the last bit leaves
  reg stop_bit = 1'b1; // stop level offered; low forces a framing error in async mode
  initial begin
    rx_data_out = 8'h00;
    {rx_parity_out, rx_mpb_out, rx_stop_out, rx_valid_out} = 4'h0;
    {tx_ready_out, tx_last_bit_out} = 2'b00;
  end
  // offer one character and hold it until the block is ready
  task send(input [7:0] d, input p, input m);
    begin
      @(posedge clk_in);
      rx_data_out <= d;
      rx_parity_out <= p;
      rx_mpb_out <= m;
      rx_stop_out <= stop_bit;
      rx_valid_out <= 1'b1;
      do @(posedge clk_in); while (!rx_ready_in);
      rx_valid_out <= 1'b0;
      // released payload turns to junk so a stale value cannot pass
      {rx_data_out, rx_parity_out, rx_mpb_out, rx_stop_out} <= {~d, ~p, ~m, 1'b0};
      repeat (3) @(posedge clk_in);
    end
  endtask
  // shifter: waits stall cycles, takes the character, pulses last bit later
  always @(posedge clk_in) begin
    tx_last_bit_out <= (shift_left == 1);
    if (shift_left == 1) tx_count <= tx_count + 1;
    if (shift_left > 0) shift_left <= shift_left - 1;
    if (tx_valid_in && tx_ready_out) begin
      tx_ready_out <= 1'b0;
      waited <= 0;
      shift_left <= 10;
    end else if (tx_valid_in && waited >= stall) tx_ready_out <= 1'b1;
    else if (tx_valid_in) waited <= waited + 1;
    else begin
      tx_ready_out <= 1'b0;
      waited <= 0;
    end
  end
endmodule

// ### test/tb.sv
// self-checking bench: register bus tasks, rate table, receive and transmit sequences
`timescale 1ns/1ps
`include "ssb_regs.vh"
module tb;
  reg clk = 1'b0, rst = 1'b1, stby = 1'b0, subact = 1'b0, wclk = 1'b0;
  reg [1:0] wcnt = 2'b00;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [31:0] wdata = 32'h0000_0000, rv;
  reg [1:0] rr;
  wire awready, wready, bvalid, arready, rvalid, rx_ready, tx_valid, tx_ready, tx_last, tick;
  wire rx_par, rx_mpb, rx_stop, rx_valid, tx_mpb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] rx_data, tx_data;
  integer mismatches = 0, checks_done = 0, cycles = 0;
  always #2.5 clk = ~clk;
  // watch clock with a rising edge every fourth cycle; cycle ceiling cuts hangs
  always @(posedge clk) begin
    wcnt <= wcnt + 2'b01;
    wclk <= wcnt[1];
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  ssb_top ssb_top_inst (.CLK_IN(clk), .RST_IN(rst), .STANDBY_IN(stby), .SUBACTIVE_IN(subact),
    .WATCH_CLK_IN(wclk), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr),
    .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
    .RVALID_OUT(rvalid), .RREADY_IN(rready), .RX_DATA_IN(rx_data), .RX_PARITY_IN(rx_par),
    .RX_MPB_IN(rx_mpb), .RX_STOP_IN(rx_stop), .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready),
    .TX_DATA_OUT(tx_data), .TX_MPB_OUT(tx_mpb), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
    .TX_LAST_BIT_IN(tx_last), .BAUD_TICK_OUT(tick));
  ssb_partner ssb_partner_inst (.clk_in(clk), .rx_ready_in(rx_ready), .rx_data_out(rx_data),
    .rx_parity_out(rx_par), .rx_mpb_out(rx_mpb), .rx_stop_out(rx_stop), .rx_valid_out(rx_valid),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_last_bit_out(tx_last));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // write: address and data offered together, each released when taken
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rr = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      {rv, rr} = {rdata, rresp};
      rready <= 1'b0;
    end
  endtask
  task rc(input string nm, input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(nm, rv, e);
    end
  endtask
  // measure one full tick period after two ticks let the setting settle
  task baud(input [7:0] ctl, input [7:0] n, input s, input [31:0] e);
    integer k;
    begin
      subact <= s;
      wr(`SSB_OFS_DIVIDER, {24'h00_0000, n});
      wr(`SSB_OFS_CONTROL, {24'h00_0000, ctl});
      repeat (2) begin
        @(posedge clk);
        while (!tick) @(posedge clk);
      end
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (!tick);
      chk("tick gap", k, e);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc("status", `SSB_OFS_STATUS, 32'h0000_0084);
    rc("divider", `SSB_OFS_DIVIDER, 32'h0000_00FF);
    wr(`SSB_OFS_DIVIDER, 32'h0000_005A);
    rc("divider", `SSB_OFS_DIVIDER, 32'h0000_005A);
    wr(8'h14, 32'h0000_0001);
    chk("unmapped wr", rr, `SSB_RESP_SLVERR);
    rc("unmapped rd", 8'h14, 32'h0000_0000);
    wr(`SSB_OFS_STATUS, 32'h0000_00FB);
    rc("status", `SSB_OFS_STATUS, 32'h0000_0085);
    $display("register test done");
    // settings divide exactly, so the rate error is zero
    baud(8'h02, 8'h00, 1'b0, 64);
    baud(8'h02, 8'h01, 1'b0, 128);
    baud(8'h82, 8'h00, 1'b0, 1024);
    baud(8'hC2, 8'h00, 1'b0, 4096);
    baud(8'h42, 8'h00, 1'b0, 512);
    baud(8'h42, 8'h00, 1'b1, 256);
    $display("rate test done");
    ssb_partner_inst.stall = 20;
    wr(`SSB_OFS_CONTROL, 32'h0000_0021);
    wr(`SSB_OFS_TXHOLD, 32'h0000_00A5);
    rc("status", `SSB_OFS_STATUS, 32'h0000_0001);
    while (!tx_valid) @(posedge clk);
    chk("tx data", tx_data, 32'h0000_00A5);
    chk("tx mpb", tx_mpb, 32'h0000_0001);
    while (ssb_partner_inst.tx_count < 1) @(posedge clk);
    repeat (2) @(posedge clk);
    rc("status", `SSB_OFS_STATUS, 32'h0000_0085);
    ssb_partner_inst.stall = 0;
    wr(`SSB_OFS_CONTROL, 32'h0000_0001);
    wr(`SSB_OFS_TXHOLD, 32'h0000_003C);
    while (!tx_valid) @(posedge clk);
    chk("tx mpb off", tx_mpb, 32'h0000_0000);
    ssb_partner_inst.stall = 20;
    while (ssb_partner_inst.tx_count < 2) @(posedge clk);
    wr(`SSB_OFS_CONTROL, 32'h0000_0021);
    wr(`SSB_OFS_TXHOLD, 32'h0000_0066);
    wr(`SSB_OFS_CONTROL, 32'h0000_0020);
    rc("status", `SSB_OFS_STATUS, 32'h0000_0085);
    chk("tx valid", tx_valid, 32'h0000_0000);
    wr(`SSB_OFS_STATUS, 32'h0000_00FE);
    $display("transmit test done");
    wr(`SSB_OFS_CONTROL, 32'h0000_002A);
    ssb_partner_inst.send(8'h03, 1'b0, 1'b1);
    rc("status", `SSB_OFS_STATUS, 32'h0000_00C6);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0003);
    wr(`SSB_OFS_CONTROL, 32'h0000_0028);
    ssb_partner_inst.send(8'h55, 1'b0, 1'b0);
    rc("status", `SSB_OFS_STATUS, 32'h0000_0086);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0003);
    wr(`SSB_OFS_CONTROL, 32'h0000_002A);
    ssb_partner_inst.send(8'h01, 1'b0, 1'b1);
    rc("status", `SSB_OFS_STATUS, 32'h0000_008E);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0001);
    wr(`SSB_OFS_CONTROL, 32'h0000_0028);
    rc("status", `SSB_OFS_STATUS, 32'h0000_008E);
    wr(`SSB_OFS_CONTROL, 32'h0000_002A);
    ssb_partner_inst.send(8'h07, 1'b1, 1'b1);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0001);
    wr(`SSB_OFS_STATUS, 32'h0000_00F6);
    rc("status", `SSB_OFS_STATUS, 32'h0000_00C6);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0007);
    wr(`SSB_OFS_CONTROL, 32'h0000_003A);
    ssb_partner_inst.send(8'h01, 1'b0, 1'b1);
    rc("status", `SSB_OFS_STATUS, 32'h0000_00C6);
    $display("receive test done");
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0001);
    ssb_partner_inst.stop_bit = 1'b0;
    ssb_partner_inst.send(8'h00, 1'b1, 1'b0);
    ssb_partner_inst.stop_bit = 1'b1;
    rc("status", `SSB_OFS_STATUS, 32'h0000_0094);
    wr(`SSB_OFS_CONTROL, 32'h0000_0007);
    wr(`SSB_OFS_TXHOLD, 32'h0000_005A);
    repeat (4) @(posedge clk);
    chk("tx blocked", tx_valid, 32'h0000_0000);
    ssb_partner_inst.send(8'h33, 1'b0, 1'b0);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0000);
    wr(`SSB_OFS_STATUS, 32'h0000_00EF);
    repeat (2) @(posedge clk);
    chk("tx freed", tx_valid, 32'h0000_0001);
    chk("tx data", tx_data, 32'h0000_005A);
    rc("rx hold", `SSB_OFS_RXHOLD, 32'h0000_0033);
    $display("sync block test done");
    wr(`SSB_OFS_DIVIDER, 32'h0000_0012);
    stby <= 1'b1;
    repeat (2) @(posedge clk);
    stby <= 1'b0;
    rc("divider", `SSB_OFS_DIVIDER, 32'h0000_00FF);
    rc("status", `SSB_OFS_STATUS, 32'h0000_0084);
    $display("standby test done");
    finish_test;
  end
endmodule
